//--- cpu_bus_pkg.sv
// Purpose: Shared constants and types for the multiplexed CPU bus block
// Assumes: APB register access, 32-bit data, byte addresses below 256
// Notes:   Opcode values are fixed encodings of the control and escape instructions
package cpu_bus_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_PC        = 8'h04;
	localparam logic [7:0] OFS_COUNT     = 8'h08;
	localparam logic [7:0] OFS_FLAGS     = 8'h0C;
	localparam logic [7:0] OFS_STATUS    = 8'h10;
	localparam logic [7:0] OFS_XFER_ADDR = 8'h14;
	localparam logic [7:0] OFS_XFER_CMD  = 8'h18;
	localparam logic [7:0] OFS_XFER_DATA = 8'h1C;
	localparam logic [7:0] OFS_LAST_OP   = 8'h20;

	// Field positions
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_DIR   = 1;
	localparam int FLAG_IE    = 2;
	localparam int CMD_WRITE  = 8;
	localparam int CMD_IO     = 9;

	// Reset values
	localparam logic [19:0] PC_RESET    = 20'h00000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;

	// Opcodes
	localparam logic [7:0] OP_CARRY_CLEAR  = 8'hF8;
	localparam logic [7:0] OP_CARRY_SET    = 8'hF9;
	localparam logic [7:0] OP_CARRY_INVERT = 8'hF5;
	localparam logic [7:0] OP_INT_CLEAR    = 8'hFA;
	localparam logic [7:0] OP_INT_SET      = 8'hFB;
	localparam logic [7:0] OP_DIR_CLEAR    = 8'hFC;
	localparam logic [7:0] OP_DIR_SET      = 8'hFD;
	localparam logic [7:0] OP_HALT         = 8'hF4;
	localparam logic [7:0] OP_WAIT         = 8'h9B;
	localparam logic [7:0] OP_LOCK         = 8'hF0;
	localparam logic [7:0] OP_REPEAT       = 8'hF3;
	localparam logic [7:0] OP_NOP          = 8'h90;
	localparam logic [4:0] OP_COPROC_HIGH  = 5'h1B;
	localparam logic [2:0] LEN_MAX         = 3'd7;

	// Cycle-type status codes
	localparam logic [2:0] CS_IO_RD   = 3'h1;
	localparam logic [2:0] CS_IO_WR   = 3'h2;
	localparam logic [2:0] CS_HALT    = 3'h3;
	localparam logic [2:0] CS_FETCH   = 3'h4;
	localparam logic [2:0] CS_MEM_RD  = 3'h5;
	localparam logic [2:0] CS_MEM_WR  = 3'h6;
	localparam logic [2:0] CS_PASSIVE = 3'h7;

	typedef enum {S_IDLE, S_XFER, S_FETCH, S_OPERAND, S_EXEC,
		S_HALT, S_WAIT} seq_state_t;
	typedef enum {B_IDLE, B_T1, B_T2, B_T3, B_T4} bus_state_t;

	typedef struct packed {
		logic [7:0] muxed_addr_data_low;
		logic       muxed_oe;
		logic [7:0] addr_mid_byte;
		logic [3:0] addr_high_status;
		logic       ale;
		logic       rd_n;
		logic       wr_n;
		logic       io_m;
		logic [2:0] cycle_status;
		logic       lock_n;
	} bus_pins_t;

endpackage

//--- cpu_bus_interface.sv
// Purpose: CPU core sequencer with a multiplexed 8-bit external bus
// Assumes: pclk 50 MHz, presetn asynchronous active low, APB slave
// Notes:   Bus inputs from pins pass two flip-flops before use
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1: Low eight lines carry address, then data
// RULE2: Address strobe marks address on shared lines
// RULE3: Address bits 8-15 held whole cycle
// RULE4: Top four lines: address, then status
// RULE5: Read or write strobe plus I/O select
// RULE6: Cycle-type status given at cycle start
// RULE7: Instructions one to seven bytes long
// RULE8: Instructions start at any byte address
// RULE9: Repeat count taken from count register
// RULE10: Carry, direction, interrupt flag instructions
// RULE11: Halt until interrupt or reset; code leaves halt on intr_pin only while int_en is set
// RULE12: Wait until test pin active
// RULE13: Lock bus during following instruction
// RULE14: Escape hands operation to external processor
// RULE15: External latch captures address, inverting option
// RULE16: External decoder may split command strobes
// RULE17: Latch transparent while strobe high
module cpu_bus_interface
	import cpu_bus_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  muxed_in,
	input  wire logic        ready_pin,
	input  wire logic        test_n_pin,
	input  wire logic        intr_pin,
	output bus_pins_t        pins,
	output logic             coproc_strobe,
	output logic      [15:0] coproc_bytes
);

	function automatic logic is_coproc(input logic [7:0] op);
		return op[7:3] == OP_COPROC_HIGH;
	endfunction

	function automatic logic is_control(input logic [7:0] op);
		return op == OP_CARRY_CLEAR || op == OP_CARRY_SET ||
			op == OP_CARRY_INVERT || op == OP_INT_CLEAR ||
			op == OP_INT_SET || op == OP_DIR_CLEAR ||
			op == OP_DIR_SET || op == OP_HALT || op == OP_WAIT ||
			op == OP_LOCK || op == OP_REPEAT || op == OP_NOP;
	endfunction

	// Total length: control ops 1, escape 2, others from low bits
	function automatic logic [2:0] insn_len(input logic [7:0] op);
		if (is_control(op))
			return 3'd1;
		if (is_coproc(op))
			return 3'd2;
		return (op[2:0] == LEN_MAX) ? LEN_MAX : op[2:0] + 3'd1;
	endfunction

	seq_state_t  state;
	bus_state_t  bstate;
	logic [10:0] sync1;
	logic [10:0] sync2;
	logic [7:0]  data_s;
	logic        ready_s;
	logic        test_n_s;
	logic        intr_s;
	logic        run;
	logic [19:0] pc;
	logic [15:0] count;
	logic        carry;
	logic        dir;
	logic        int_en;
	logic [7:0]  opcode;
	logic [7:0]  operand;
	logic [2:0]  remain;
	logic        lock_arm;
	logic        rep_arm;
	logic [19:0] xfer_addr;
	logic [7:0]  xfer_wdata;
	logic [2:0]  xfer_cs;
	logic        xfer_pend;
	logic [7:0]  xfer_rdata;
	logic        bus_done;
	logic [7:0]  bus_rdata;
	logic [2:0]  cur_cs;
	logic [7:0]  cur_wdata;
	logic        req;
	logic [2:0]  req_cs;
	logic [19:0] req_addr;
	logic        wr_en;
	logic        mapped;
	logic [31:0] rd_mux;
	logic        rep_loop;
	logic        exec_end;

	assign data_s   = sync2[7:0];
	assign ready_s  = sync2[8];
	assign test_n_s = sync2[9];
	assign intr_s   = sync2[10];

	// Pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 11'h200;
			sync2 <= 11'h200;
		end else begin
			sync1 <= {intr_pin, test_n_pin, ready_pin, muxed_in};
			sync2 <= sync1;
		end
	end

	// Bus request from the sequencer
	always_comb begin
		req      = 1'b0;
		req_cs   = CS_FETCH;
		req_addr = pc;
		if (bstate == B_IDLE && !bus_done) begin
			if (state == S_FETCH || state == S_OPERAND) begin
				req = 1'b1;
			end else if (state == S_XFER) begin
				req      = 1'b1;
				req_cs   = xfer_cs;
				req_addr = xfer_addr;
			end
		end
	end

	assign rep_loop = rep_arm && !is_control(opcode) && !is_coproc(opcode)
		&& count != 16'h0000; // RULE9
	assign exec_end = state == S_EXEC && opcode != OP_LOCK &&
		opcode != OP_REPEAT && !rep_loop;

	// Instruction sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state    <= S_IDLE;
			opcode   <= OP_NOP;
			operand  <= 8'h00;
			remain   <= 3'd0;
			lock_arm <= 1'b0;
			rep_arm  <= 1'b0;
		end else begin
			case (state)
			S_IDLE: begin
				if (xfer_pend)
					state <= S_XFER;
				else if (run)
					state <= S_FETCH;
			end
			S_XFER: begin
				if (bus_done)
					state <= S_IDLE;
			end
			S_FETCH: begin
				if (bus_done) begin
					opcode <= bus_rdata;
					remain <= insn_len(bus_rdata) - 3'd1; // RULE7
					if (insn_len(bus_rdata) == 3'd1)
						state <= S_EXEC;
					else
						state <= S_OPERAND;
				end
			end
			S_OPERAND: begin
				if (bus_done) begin
					if (remain == insn_len(opcode) - 3'd1)
						operand <= bus_rdata;
					remain <= remain - 3'd1;
					if (remain == 3'd1)
						state <= S_EXEC;
				end
			end
			S_EXEC: begin
				if (opcode == OP_LOCK) begin
					lock_arm <= 1'b1; // RULE13
					state    <= S_FETCH;
				end else if (opcode == OP_REPEAT) begin
					rep_arm <= 1'b1;
					state   <= S_FETCH;
				end else if (!rep_loop) begin
					rep_arm  <= 1'b0;
					lock_arm <= 1'b0; // RULE13
					if (opcode == OP_HALT)
						state <= S_HALT;
					else if (opcode == OP_WAIT)
						state <= S_WAIT;
					else
						state <= S_IDLE;
				end
			end
			S_HALT: begin
				if (intr_s && int_en)
					state <= S_IDLE; // RULE11
			end
			S_WAIT: begin
				if (!test_n_s)
					state <= S_IDLE; // RULE12
			end
			default: state <= S_IDLE;
			endcase
		end
	end

	// Program counter advances one byte per fetched byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pc <= PC_RESET;
		else if (wr_en && paddr == OFS_PC)
			pc <= pwdata[19:0];
		else if (bus_done && (state == S_FETCH || state == S_OPERAND))
			pc <= pc + 20'd1; // RULE8
	end

	// Flags and count register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carry  <= 1'b0;
			dir    <= 1'b0;
			int_en <= 1'b0;
			count  <= COUNT_RESET;
		end else begin
			if (wr_en && paddr == OFS_FLAGS) begin
				carry  <= pwdata[FLAG_CARRY];
				dir    <= pwdata[FLAG_DIR];
				int_en <= pwdata[FLAG_IE];
			end
			if (wr_en && paddr == OFS_COUNT)
				count <= pwdata[15:0];
			if (state == S_EXEC && rep_loop)
				count <= count - 16'd1; // RULE9
			if (state == S_EXEC) begin
				case (opcode)
				OP_CARRY_SET:    carry  <= 1'b1; // RULE10
				OP_CARRY_CLEAR:  carry  <= 1'b0; // RULE10
				OP_CARRY_INVERT: carry  <= !carry; // RULE10
				OP_DIR_SET:      dir    <= 1'b1; // RULE10
				OP_DIR_CLEAR:    dir    <= 1'b0; // RULE10
				OP_INT_SET:      int_en <= 1'b1; // RULE10
				OP_INT_CLEAR:    int_en <= 1'b0; // RULE10
				default:         carry  <= carry;
				endcase
			end
		end
	end

	// Escape hand-off to the external processor
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			coproc_strobe <= 1'b0;
			coproc_bytes  <= 16'h0000;
		end else begin
			coproc_strobe <= exec_end && is_coproc(opcode); // RULE14
			if (exec_end && is_coproc(opcode))
				coproc_bytes <= {opcode, operand}; // RULE14
		end
	end

	// External bus cycle engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bstate    <= B_IDLE;
			bus_done  <= 1'b0;
			bus_rdata <= 8'h00;
			cur_cs    <= CS_PASSIVE;
			cur_wdata <= 8'h00;
			pins      <= '{muxed_addr_data_low: 8'h00, muxed_oe: 1'b0,
				addr_mid_byte: 8'h00, addr_high_status: 4'h0,
				ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, io_m: 1'b0,
				cycle_status: CS_PASSIVE, lock_n: 1'b1};
		end else begin
			bus_done    <= 1'b0;
			pins.lock_n <= !lock_arm; // RULE13
			case (bstate)
			B_IDLE: begin
				if (req) begin
					bstate    <= B_T1;
					cur_cs    <= req_cs;
					cur_wdata <= xfer_wdata;
					pins.ale  <= 1'b1; // RULE2
					pins.muxed_addr_data_low <= req_addr[7:0]; // RULE1
					pins.muxed_oe         <= 1'b1;
					pins.addr_mid_byte    <= req_addr[15:8]; // RULE3
					pins.addr_high_status <= req_addr[19:16]; // RULE4
					pins.cycle_status     <= req_cs; // RULE6
					pins.io_m <= req_cs == CS_IO_RD || req_cs == CS_IO_WR;
				end else begin
					pins.cycle_status <= (state == S_HALT) ?
						CS_HALT : CS_PASSIVE; // RULE6
				end
			end
			B_T1: begin
				bstate   <= B_T2;
				pins.ale <= 1'b0; // RULE2
				pins.addr_high_status <= {lock_arm, int_en,
					cur_cs == CS_MEM_WR || cur_cs == CS_IO_WR,
					cur_cs == CS_FETCH}; // RULE4
				if (cur_cs == CS_MEM_WR || cur_cs == CS_IO_WR) begin
					pins.muxed_addr_data_low <= cur_wdata; // RULE1
					pins.wr_n <= 1'b0; // RULE5
				end else begin
					pins.muxed_oe <= 1'b0; // RULE1
					pins.rd_n     <= 1'b0; // RULE5
				end
			end
			B_T2: bstate <= B_T3;
			B_T3: begin
				if (ready_s)
					bstate <= B_T4;
			end
			B_T4: begin
				bstate            <= B_IDLE;
				bus_done          <= 1'b1;
				bus_rdata         <= data_s; // RULE1
				pins.rd_n         <= 1'b1;
				pins.wr_n         <= 1'b1;
				pins.muxed_oe     <= 1'b0;
				pins.cycle_status <= CS_PASSIVE;
			end
			default: bstate <= B_IDLE;
			endcase
		end
	end

	// Software control and direct transfer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run        <= 1'b0;
			xfer_addr  <= 20'h00000;
			xfer_wdata <= 8'h00;
			xfer_cs    <= CS_MEM_RD;
			xfer_pend  <= 1'b0;
			xfer_rdata <= 8'h00;
		end else begin
			if (state == S_XFER && bus_done) begin
				xfer_pend <= 1'b0;
				if (!(xfer_cs == CS_MEM_WR || xfer_cs == CS_IO_WR))
					xfer_rdata <= bus_rdata;
			end
			if (wr_en && paddr == OFS_CTRL)
				run <= pwdata[0];
			if (wr_en && paddr == OFS_XFER_ADDR)
				xfer_addr <= pwdata[19:0];
			if (wr_en && paddr == OFS_XFER_CMD && !xfer_pend) begin
				xfer_pend  <= 1'b1;
				xfer_wdata <= pwdata[7:0];
				case ({pwdata[CMD_IO], pwdata[CMD_WRITE]})
				2'b00:   xfer_cs <= CS_MEM_RD;
				2'b01:   xfer_cs <= CS_MEM_WR;
				2'b10:   xfer_cs <= CS_IO_RD;
				default: xfer_cs <= CS_IO_WR;
				endcase
			end
		end
	end

	// Register read decode
	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h00000000;
		case (paddr)
		OFS_CTRL:      rd_mux = {31'h0, run};
		OFS_PC:        rd_mux = {12'h000, pc};
		OFS_COUNT:     rd_mux = {16'h0000, count};
		OFS_FLAGS:     rd_mux = {29'h0, int_en, dir, carry};
		OFS_STATUS:    rd_mux = {26'h0, lock_arm, rep_arm, xfer_pend,
			bstate != B_IDLE, state == S_WAIT, state == S_HALT};
		OFS_XFER_ADDR: rd_mux = {12'h000, xfer_addr};
		OFS_XFER_CMD:  rd_mux = {22'h0, xfer_cs == CS_IO_RD ||
			xfer_cs == CS_IO_WR, xfer_cs == CS_MEM_WR ||
			xfer_cs == CS_IO_WR, xfer_wdata};
		OFS_XFER_DATA: rd_mux = {24'h000000, xfer_rdata};
		OFS_LAST_OP:   rd_mux = {16'h0000, opcode, operand};
		default:       mapped = 1'b0;
		endcase
	end

	assign wr_en = psel && penable && pready && pwrite && !pslverr;

	// APB answer: one access cycle, no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready <= psel && !penable;
			if (psel && !penable) begin
				pslverr <= !mapped;
				prdata  <= (pwrite || !mapped) ? 32'h00000000 : rd_mux;
			end else if (!psel) begin
				pslverr <= 1'b0;
				prdata  <= 32'h00000000;
			end
		end
	end

endmodule

`default_nettype wire

//--- cpu_bus_props.sv
// Purpose: Bus timing checks for the CPU bus block
// Assumes: One clock domain, reset active low
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_props
	import cpu_bus_pkg::*;
(
	input wire logic      pclk,
	input wire logic      presetn,
	input wire logic      pready,
	input wire bus_pins_t pins,
	input wire logic      coproc_strobe
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_t1; pins.ale; endsequence
	sequence s_t2; !pins.ale && pins.rd_n != pins.wr_n; endsequence
	property p_ale_once; s_t1 |=> !pins.ale; endproperty
	property p_addr_oe; s_t1 |-> pins.muxed_oe; endproperty
	property p_strobe; s_t1 |=> s_t2; endproperty
	property p_mid_hold; !pins.ale |-> $stable(pins.addr_mid_byte); endproperty
	property p_status; s_t1 |-> pins.cycle_status != CS_PASSIVE; endproperty
	property p_high; s_t1 ##1 s_t2 |-> pins.addr_high_status[1:0] ==
		{!pins.wr_n, pins.cycle_status == CS_FETCH}; endproperty
	property p_cyc_end; s_t1 |-> ##[4:60] (pins.rd_n && pins.wr_n &&
		pins.cycle_status == CS_PASSIVE); endproperty
	property p_coproc; coproc_strobe |=> !coproc_strobe; endproperty
	property p_ready; pready |=> !pready; endproperty
	a_ale_once: assert property (p_ale_once)
		else $error("address strobe too long");
	a_addr_oe: assert property (p_addr_oe)
		else $error("low lines not driven in address phase");
	a_strobe: assert property (p_strobe)
		else $error("no single strobe after address");
	a_mid_hold: assert property (p_mid_hold)
		else $error("middle address moved in cycle");
	a_status: assert property (p_status)
		else $error("no cycle status at start");
	a_high: assert property (p_high)
		else $error("wrong status on high lines");
	a_cyc_end: assert property (p_cyc_end)
		else $error("bus cycle did not end");
	a_coproc: assert property (p_coproc)
		else $error("escape pulse too long");
	a_ready: assert property (p_ready)
		else $error("pready too long");
endmodule
bind cpu_bus_interface cpu_bus_props props_u (.pclk(pclk),
	.presetn(presetn), .pready(pready), .pins(pins),
	.coproc_strobe(coproc_strobe));
`default_nettype wire

//--- cpu_bus_mem.sv
// Purpose: Latch, memory and port model on the far side of the bus
// Assumes: 256 bytes addressed by the latched low address byte
// Notes:   slow holds ready low for several cycles
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_mem
	import cpu_bus_pkg::*;
(
	input  wire logic       pclk,
	input  wire bus_pins_t  pins,
	input  wire logic       slow,
	output logic      [7:0] muxed_in,
	output logic            ready_pin
);
	logic [7:0] mem [256];
	logic [7:0] latch_q  = 8'h00;
	logic [7:0] last_q   = 8'h00;
	logic       rd_hold  = 1'b0;
	logic       last_io  = 1'b0;
	logic [3:0] wait_cnt = 4'h0;
	logic [3:0] rd_cnt   = 4'h0;
	logic [3:0] rd_len   = 4'h0;
	logic [19:0] addr_q  = 20'h00000;
	logic       lock_seen = 1'b0;
	// When slow, ready only inside a strobe, so no stale ready from idle time
	assign ready_pin = !slow ||
		(wait_cnt > 4'h5 && (!pins.rd_n || !pins.wr_n));
	// Released lines show the inverse of the last byte
	assign muxed_in = (!pins.rd_n || rd_hold) ? mem[latch_q] : ~last_q;
	always @(posedge pclk) begin
		if (pins.ale)
			latch_q <= pins.muxed_addr_data_low;
		if (pins.ale)
			addr_q <= {pins.addr_high_status, pins.addr_mid_byte,
				pins.muxed_addr_data_low};
		if (pins.ale && !pins.lock_n)
			lock_seen <= 1'b1;
		rd_cnt <= pins.rd_n ? 4'h0 : rd_cnt + 4'h1;
		if (pins.rd_n && rd_cnt != 4'h0)
			rd_len <= rd_cnt;
		if (!pins.wr_n) begin
			mem[latch_q] <= pins.muxed_addr_data_low;
			last_io <= pins.io_m;
		end
		rd_hold <= !pins.rd_n;
		last_q <= muxed_in;
		wait_cnt <= pins.ale ? 4'h0 : wait_cnt + 4'(wait_cnt != 4'hF);
	end
endmodule
`default_nettype wire

//--- muxed_cpu_bus_interface_bench.sv
// Purpose: Self-checking bench for the CPU bus block
// Assumes: APB master in the bench, memory model on the bus
// Notes:   Program starts at an odd address
`timescale 1ns/1ps
`default_nettype none
module muxed_cpu_bus_interface_bench
	import cpu_bus_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, perr;
	logic [7:0]  paddr, muxed_in;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, ready_pin, test_n_pin, intr_pin;
	logic        coproc_strobe, slow;
	logic [15:0] coproc_bytes;
	bus_pins_t   pins;
	int          err_total, check_count, coproc_seen;
	cpu_bus_interface dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .muxed_in(muxed_in),
		.ready_pin(ready_pin), .test_n_pin(test_n_pin),
		.intr_pin(intr_pin), .pins(pins),
		.coproc_strobe(coproc_strobe), .coproc_bytes(coproc_bytes));
	cpu_bus_mem part_u (.pclk(pclk), .pins(pins), .slow(slow),
		.muxed_in(muxed_in), .ready_pin(ready_pin));
	always #10 pclk = ~pclk;
	always @(posedge pclk) begin
		if (coproc_strobe === 1'b1)
			coproc_seen++;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_total++;
			close_out();
		end
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_st(input int b, input logic v);
		int n = 0;
		do begin
			apb(0, OFS_STATUS, 0);
			n++;
		end while (r[b] !== v && n < 300);
		if (r[b] !== v) begin
			err_total++;
			close_out();
		end
	endtask
	task automatic t_regs();
		chk("cyc_status", 32'(pins.cycle_status), 32'(CS_PASSIVE));
		chk("lock_n", 32'(pins.lock_n), 1);
		apb(0, OFS_FLAGS, 0);
		chk("flags_rst", r, 0);
		apb(1, OFS_COUNT, 32'h1234);
		apb(0, OFS_COUNT, 0);
		chk("count", r, 32'h1234);
		apb(0, 8'h40, 0);
		chk("unmapped_err", 32'(perr), 1);
		chk("unmapped_data", r, 0);
		$display("regs done");
	endtask
	task automatic t_xfer();
		apb(1, OFS_XFER_ADDR, 32'h5A3C7);
		apb(1, OFS_XFER_CMD, 32'h3A5);
		wait_st(3, 0);
		chk("wr_byte", 32'(part_u.mem[8'hC7]), 32'hA5);
		chk("wr_io", 32'(part_u.last_io), 1);
		chk("wr_addr", 32'(part_u.addr_q), 32'h5A3C7);
		part_u.mem[8'h44] = 8'h3C;
		slow <= 1'b1;
		apb(1, OFS_XFER_ADDR, 32'h00044);
		apb(1, OFS_XFER_CMD, 32'h000);
		wait_st(3, 0);
		apb(0, OFS_XFER_DATA, 0);
		chk("rd_byte", r, 32'h3C);
		chk("rd_wait", 32'(part_u.rd_len > 4'h3), 1);
		slow <= 1'b0;
		$display("xfer done");
	endtask
	task automatic t_prog();
		logic [7:0] p [20] = '{8'hF0, 8'hF9, 8'hFD, 8'hFB, 8'hF5,
			8'h07, 1, 2, 3, 4, 5, 6, 8'hF3, 8'h00, 8'hD8, 8'h77,
			8'hF4, 8'h9B, 8'hF9, 8'hF4};
		for (int i = 0; i < 20; i++)
			part_u.mem[8'h13 + i] = p[i];
		apb(1, OFS_COUNT, 3);
		apb(1, OFS_PC, 32'h13);
		apb(1, OFS_CTRL, 1);
		wait_st(0, 1);
		chk("coproc", 32'(coproc_bytes), 32'hD877);
		chk("coproc_pulse", coproc_seen, 1);
		apb(0, OFS_FLAGS, 0);
		chk("flags", r, 6);
		apb(0, OFS_COUNT, 0);
		chk("count_end", r, 0);
		chk("lock_seen", 32'(part_u.lock_seen), 1);
		chk("lock_free", 32'(pins.lock_n), 1);
		intr_pin <= 1'b1;
		wait_st(1, 1);
		chk("woke", r[0], 0);
		intr_pin <= 1'b0;
		test_n_pin <= 1'b0;
		wait_st(0, 1);
		apb(0, OFS_FLAGS, 0);
		chk("flags_end", r, 7);
		test_n_pin <= 1'b1;
		$display("program done");
	endtask
	initial begin
		pclk = 0;
		presetn = 0;
		{psel, penable, pwrite, intr_pin, slow} = '0;
		test_n_pin = 1;
		paddr = 0;
		pwdata = 0;
		err_total = 0;
		check_count = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_xfer();
		t_prog();
		close_out();
	end
endmodule
`default_nettype wire
